//--- testbench/byte_port_monitor.sv
// Checker for byte port registers and slave pins
`timescale 1ns/1ps
`default_nettype none
module byte_port_monitor (
    // Clock, reset, register port
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // Pins
    input wire logic [7:0] BP_OE,
    input wire logic [2:0] CP_IN,
    input wire logic [2:0] CP_OE,
    input wire logic XFER_DONE
);
    logic [7:0] bdir_reg;
    logic [2:0] cdir_reg;
    logic mode_reg;
    logic [5:0] hist_reg;
    logic [2:0] hi_reg;
    logic [2:0] acfg_reg;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    // Shadow of software fields and pin history
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bdir_reg <= 8'hFF;
            cdir_reg <= 3'h7;
            mode_reg <= 1'b0;
            acfg_reg <= 3'h0;
            hist_reg <= 6'h00;
            hi_reg <= 3'h0;
        end else begin
            if (WR && ADDR == 8'h88) begin
                bdir_reg <= WDATA;
            end
            if (WR && ADDR == 8'h89) begin
                cdir_reg <= WDATA[2:0];
                mode_reg <= WDATA[4];
            end
            if (WR && ADDR == 8'h9F) begin
                acfg_reg <= WDATA[2:0];
            end
            hist_reg <= {hist_reg[4:0], ~CP_IN[0] & ~CP_IN[2]};
            hi_reg <= !CP_IN[2] ? 3'h0 : (hi_reg == 3'h7 ? hi_reg : hi_reg + 3'h1);
        end
    end
    // Assertions
    a_byte_dir_read: assert property (
        RD && ADDR == 8'h88 |=> RDATA == $past(bdir_reg)) else $error("byte dir readback");
    a_ctrl_fields: assert property (
        RD && ADDR == 8'h89 |=> RDATA[4:0] == {$past(mode_reg), 1'b0, $past(cdir_reg)})
        else $error("control fields readback");
    a_ctrl_oe: assert property (
        CP_OE == ~$past(cdir_reg)) else $error("control pin enable");
    a_byte_oe_gen: assert property (
        !mode_reg && !$past(mode_reg) |-> BP_OE == ~$past(bdir_reg)) else $error("byte enable");
    a_read_drive: assert property (
        mode_reg && $past(mode_reg) && BP_OE != 8'h00 |-> BP_OE == 8'hFF && hist_reg != 6'h00)
        else $error("byte drive without read");
    a_read_start: assert property (
        mode_reg && $fell(CP_IN[0]) && CP_IN == 3'b010 |-> ##[3:5] BP_OE == 8'hFF)
        else $error("read not driven");
    a_done_mode: assert property (
        XFER_DONE |-> $past(mode_reg)) else $error("done outside slave mode");
    a_select_idle: assert property (
        hi_reg == 3'h7 |-> !XFER_DONE) else $error("done while deselected");
    a_done_pulse: assert property (
        XFER_DONE |=> !XFER_DONE) else $error("done too long");
    a_status_general: assert property (
        RD && ADDR == 8'h89 && !mode_reg && !$past(mode_reg) |=> RDATA[7:6] == 2'b00)
        else $error("full bits set outside slave mode");
    a_analog_zero: assert property (
        RD && ADDR == 8'h09 && acfg_reg[2:1] != 2'b11 |=> RDATA == 8'h00)
        else $error("analog control pins not zero");
    // Main scenarios
    c_done: cover property (XFER_DONE);
    c_status: cover property (RD && ADDR == 8'h89);
    c_drive: cover property (mode_reg && BP_OE == 8'hFF);
endmodule
`default_nettype wire

//--- testbench/ext_cpu.sv
// Model of the external processor on the slave pins
`timescale 1ns/1ps
`default_nettype none
module ext_cpu (
    // Clock and byte pin levels
    input wire logic CLK,
    input wire logic [7:0] pins,
    // Drives towards the device
    output logic [2:0] cp_drv,
    output logic [7:0] bus_drv
);
    initial begin
        cp_drv = 3'h7;
        bus_drv = 8'h00;
    end
    // One strobed transfer held five cycles; the bus shows the inverse when released
    task automatic xfer(input logic rd_op, input logic sel_n, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge CLK);
        bus_drv <= rd_op ? ~bus_drv : d;
        cp_drv <= {sel_n, rd_op, ~rd_op};
        repeat (5) @(posedge CLK);
        q = pins;
        cp_drv <= 3'h7;
        bus_drv <= ~(rd_op ? q : d);
        repeat (6) @(posedge CLK);
    endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the byte port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic CLK, RST, WR, RD, XFER_DONE;
    logic [7:0] ADDR, WDATA, RDATA, BP_OUT, BP_OE, pins, bus_drv, q, d, r;
    logic [2:0] CP_OUT, CP_OE, cp_drv, cp_pins;
    logic [31:0] seed;
    logic [7:0] dones;
    int mismatches, checks_done;
    // Wire levels from both parties
    assign pins = (BP_OE & BP_OUT) | (~BP_OE & bus_drv);
    assign cp_pins = (CP_OE & CP_OUT) | (~CP_OE & cp_drv);
    byte_port i_dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .BP_IN(pins), .BP_OUT(BP_OUT), .BP_OE(BP_OE), .CP_IN(cp_pins),
        .CP_OUT(CP_OUT), .CP_OE(CP_OE), .XFER_DONE(XFER_DONE));
    ext_cpu i_cpu (.CLK(CLK), .pins(pins), .cp_drv(cp_drv), .bus_drv(bus_drv));
    // Completed slave transfers seen on the done pulse
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            dones <= 8'h00;
        end else if (XFER_DONE) begin
            dones <= dones + 8'h01;
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Latch bits where driven, outside level where input
    function automatic logic [7:0] mix(input logic [7:0] v, input logic [7:0] dir,
                                       input logic [7:0] ext);
        return (v & ~dir) | (ext & dir);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        check(RDATA, exp);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge CLK);
        mismatches++;
        finish_test;
    end
    initial begin
        RST = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 8'h00;
        WDATA = 8'h00;
        seed = 32'h8ae5_bcef;
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        // Reset values, reserved and unmapped places
        rd_chk(8'h88, 8'hFF);
        rd_chk(8'h89, 8'h07);
        rd_chk(8'h9F, 8'h00);
        rd_chk(8'h09, 8'h00);
        rd_chk(8'h10, 8'h00);
        wr(8'h89, 8'hEF);
        rd_chk(8'h89, 8'h27);
        wr(8'h89, 8'h07);
        rd_chk(8'h89, 8'h07);
        // Random directions and data in general mode
        wr(8'h9F, 8'h06);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            d = seed[7:0];
            r = seed[15:8];
            wr(8'h88, r);
            wr(8'h08, d);
            wr(8'h89, {5'h00, r[2:0]});
            wr(8'h09, d);
            repeat (4) @(posedge CLK);
            rd_chk(8'h08, mix(d, r, bus_drv));
            rd_chk(8'h09, mix(d & 8'h07, r & 8'h07, 8'h07));
        end
        wr(8'h89, 8'h07);
        wr(8'h9F, 8'h00);
        rd_chk(8'h09, 8'h00);
        // Slave mode, pins set as digital inputs first
        wr(8'h9F, 8'h06);
        wr(8'h89, 8'h17);
        seed = lfsr(seed);
        i_cpu.xfer(1'b0, 1'b0, seed[7:0], q);
        check(dones, 8'h01);
        rd_chk(8'h89, 8'h97);
        i_cpu.xfer(1'b0, 1'b0, seed[15:8], q);
        rd_chk(8'h89, 8'hB7);
        rd_chk(8'h08, seed[15:8]);
        rd_chk(8'h89, 8'h37);
        wr(8'h08, seed[23:16]);
        rd_chk(8'h89, 8'h77);
        i_cpu.xfer(1'b1, 1'b0, 8'h00, q);
        check(q, seed[23:16]);
        rd_chk(8'h89, 8'h37);
        wr(8'h08, seed[31:24]);
        i_cpu.xfer(1'b0, 1'b1, 8'h5A, q);
        i_cpu.xfer(1'b1, 1'b1, 8'h00, q);
        rd_chk(8'h89, 8'h77);
        check(dones, 8'h03);
        wr(8'h89, 8'h27);
        rd_chk(8'h89, 8'h27);
        finish_test;
    end
endmodule
bind byte_port byte_port_monitor i_mon (.*);
`default_nettype wire

//--- verilog/byte_port.v
// Eight-bit port and three-pin control port with parallel slave mode
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "byte_port_map.vh"

module byte_port (
    // Clock and reset
    input wire CLK,
    input wire RST,
    // Register port
    input wire [7:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    // Byte port pins
    input wire [7:0] BP_IN,
    output reg [7:0] BP_OUT,
    output reg [7:0] BP_OE,
    // Control port pins
    input wire [2:0] CP_IN,
    output reg [2:0] CP_OUT,
    output reg [2:0] CP_OE,
    // Slave transfer completion
    output reg XFER_DONE
);

    // ************************************************************
    // Local definitions
    // ************************************************************

    // One-hot states of the slave transfer tracker
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WRITE = 3'b010;
    localparam [2:0] ST_READ = 3'b100;

    // Control pins that read as analog for a given configuration field
    function [2:0] analog_mask;
        input [2:0] field;
        begin
            if (field[2:1] == 2'b11) begin
                analog_mask = 3'b000;
            end else begin
                analog_mask = 3'b111;
            end
        end
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************

    // Pin synchronisers
    reg [7:0] bp_meta_reg;
    reg [7:0] bp_sync_reg;
    reg [2:0] cp_meta_reg;
    reg [2:0] cp_sync_reg;

    // Software visible state
    reg [7:0] byte_latch_reg;
    reg [7:0] byte_latch_next;
    reg [7:0] byte_dir_reg;
    reg [7:0] byte_dir_next;
    reg [2:0] ctrl_latch_reg;
    reg [2:0] ctrl_latch_next;
    reg [2:0] ctrl_dir_reg;
    reg [2:0] ctrl_dir_next;
    reg [2:0] analog_cfg_reg;
    reg [2:0] analog_cfg_next;
    reg mode_reg;
    reg mode_next;

    // Slave interface state
    reg [7:0] in_latch_reg;
    reg [7:0] in_latch_next;
    reg in_full_reg;
    reg in_full_next;
    reg out_full_reg;
    reg out_full_next;
    reg in_ovf_reg;
    reg in_ovf_next;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg done_next;

    // Decoded strobes and register access
    wire rd_sel_n;
    wire wr_sel_n;
    wire cs_n;
    wire ext_write;
    wire ext_read;
    wire wr_byte;
    wire wr_ctrl;
    wire wr_bdir;
    wire wr_cdir;
    wire wr_acfg;
    wire rd_byte;
    wire [2:0] ctrl_pins;
    wire [7:0] status_word;
    reg [7:0] rdata_next;
    reg [7:0] oe_next;

    // ************************************************************
    // Input synchronisers
    // ************************************************************

    // Two flops on every pin before any logic reads it
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            bp_meta_reg <= 8'h00;
            bp_sync_reg <= 8'h00;
            cp_meta_reg <= 3'h7;
            cp_sync_reg <= 3'h7;
        end else begin
            bp_meta_reg <= BP_IN;
            bp_sync_reg <= bp_meta_reg;
            cp_meta_reg <= CP_IN;
            cp_sync_reg <= cp_meta_reg;
        end
    end

    // ************************************************************
    // Slave strobe decode
    // ************************************************************

    // Control pins serve as strobes only in slave mode
    assign rd_sel_n = cp_sync_reg[`PIN_READ];
    assign wr_sel_n = cp_sync_reg[`PIN_WRITE];
    assign cs_n = cp_sync_reg[`PIN_SELECT];

    // Strobes count only while select is low
    assign ext_write = mode_reg & ~cs_n & ~wr_sel_n;
    assign ext_read = mode_reg & ~cs_n & ~rd_sel_n;

    // ************************************************************
    // Register port decode
    // ************************************************************

    // Write and read hits per register
    assign wr_byte = WR & (ADDR == `OFS_BYTE_DATA);
    assign wr_ctrl = WR & (ADDR == `OFS_CTRL_DATA);
    assign wr_bdir = WR & (ADDR == `OFS_BYTE_DIR);
    assign wr_cdir = WR & (ADDR == `OFS_CTRL_DIR_STAT);
    assign wr_acfg = WR & (ADDR == `OFS_ANALOG_CFG);
    assign rd_byte = RD & (ADDR == `OFS_BYTE_DATA);

    // Analog pins read as zero
    assign ctrl_pins = cp_sync_reg & ~analog_mask(analog_cfg_reg);

    // Status and direction word, bit 3 always zero
    assign status_word = {in_full_reg, out_full_reg, in_ovf_reg, mode_reg,
                          1'b0, ctrl_dir_reg};

    // ************************************************************
    // Software register updates
    // ************************************************************

    // Plain read/write configuration registers
    always @* begin
        byte_dir_next = byte_dir_reg;
        ctrl_dir_next = ctrl_dir_reg;
        ctrl_latch_next = ctrl_latch_reg;
        analog_cfg_next = analog_cfg_reg;
        mode_next = mode_reg;
        if (wr_bdir) begin
            byte_dir_next = WDATA;
        end
        if (wr_ctrl) begin
            ctrl_latch_next = WDATA[2:0];
        end
        if (wr_cdir) begin
            ctrl_dir_next = WDATA[2:0];
            mode_next = WDATA[`BIT_SLAVE_MODE];
        end
        if (wr_acfg) begin
            analog_cfg_next = WDATA[2:0];
        end
    end

    // Output latch of the byte port, shared by both modes
    always @* begin
        byte_latch_next = byte_latch_reg;
        if (wr_byte) begin
            byte_latch_next = WDATA;
        end
    end

    // ************************************************************
    // Slave transfer tracker
    // ************************************************************

    // Follows one external write or read from start to end
    always @* begin
        state_next = state_reg;
        in_latch_next = in_latch_reg;
        done_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (ext_write) begin
                    state_next = ST_WRITE;
                    in_latch_next = bp_sync_reg;
                end else if (ext_read) begin
                    state_next = ST_READ;
                end
            end
            ST_WRITE: begin
                if (ext_write) begin
                    in_latch_next = bp_sync_reg;
                end else begin
                    state_next = ST_IDLE;
                    done_next = mode_reg;
                end
            end
            ST_READ: begin
                if (!ext_read) begin
                    state_next = ST_IDLE;
                    done_next = mode_reg;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Slave status flags
    // ************************************************************

    // Input-full: set at write end, cleared by a core read or by leaving slave mode
    always @* begin
        if (!mode_reg) begin
            in_full_next = 1'b0;
        end else if ((state_reg == ST_WRITE) && !ext_write) begin
            in_full_next = 1'b1;
        end else if (rd_byte) begin
            in_full_next = 1'b0;
        end else begin
            in_full_next = in_full_reg;
        end
    end

    // Output-full: set by a core write, cleared at external read start
    always @* begin
        if (!mode_reg) begin
            out_full_next = 1'b0;
        end else if (wr_byte) begin
            out_full_next = 1'b1;
        end else if ((state_reg == ST_IDLE) && !ext_write && ext_read) begin
            out_full_next = 1'b0;
        end else begin
            out_full_next = out_full_reg;
        end
    end

    // Overflow: set on a new write over an unread byte; set beats clear
    always @* begin
        if ((state_reg == ST_IDLE) && ext_write && in_full_reg) begin
            in_ovf_next = 1'b1;
        end else if (wr_cdir) begin
            in_ovf_next = WDATA[`BIT_IN_OVF];
        end else begin
            in_ovf_next = in_ovf_reg;
        end
    end

    // ************************************************************
    // Read data and pin drive
    // ************************************************************

    // Read data for the cycle after a read strobe, zero otherwise
    always @* begin
        rdata_next = 8'h00;
        if (RD) begin
            case (ADDR)
                `OFS_BYTE_DATA: begin
                    if (mode_reg) begin
                        rdata_next = in_latch_reg;
                    end else begin
                        rdata_next = bp_sync_reg;
                    end
                end
                `OFS_CTRL_DATA: begin
                    rdata_next = {5'h00, ctrl_pins};
                end
                `OFS_BYTE_DIR: begin
                    rdata_next = byte_dir_reg;
                end
                `OFS_CTRL_DIR_STAT: begin
                    rdata_next = status_word;
                end
                `OFS_ANALOG_CFG: begin
                    rdata_next = {5'h00, analog_cfg_reg};
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    // Byte port drive: direction register in general mode, read strobe in slave mode
    always @* begin
        if (mode_reg) begin
            oe_next = ext_read ? 8'hFF : 8'h00;
        end else begin
            oe_next = ~byte_dir_reg;
        end
    end

    // ************************************************************
    // State registers
    // ************************************************************

    // Configuration and status registers
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            byte_dir_reg <= `RST_BYTE_DIR;
            ctrl_dir_reg <= `RST_CTRL_DIR;
            ctrl_latch_reg <= 3'h0;
            analog_cfg_reg <= `RST_ANALOG_CFG;
            mode_reg <= 1'b0;
            in_full_reg <= 1'b0;
            out_full_reg <= 1'b0;
            in_ovf_reg <= 1'b0;
        end else begin
            byte_dir_reg <= byte_dir_next;
            ctrl_dir_reg <= ctrl_dir_next;
            ctrl_latch_reg <= ctrl_latch_next;
            analog_cfg_reg <= analog_cfg_next;
            mode_reg <= mode_next;
            in_full_reg <= in_full_next;
            out_full_reg <= out_full_next;
            in_ovf_reg <= in_ovf_next;
        end
    end

    // Data latches and transfer state
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            byte_latch_reg <= `RST_BYTE_LATCH;
            in_latch_reg <= 8'h00;
            state_reg <= ST_IDLE;
        end else begin
            byte_latch_reg <= byte_latch_next;
            in_latch_reg <= in_latch_next;
            state_reg <= state_next;
        end
    end

    // Registered outputs
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 8'h00;
            BP_OUT <= `RST_BYTE_LATCH;
            BP_OE <= 8'h00;
            CP_OUT <= 3'h0;
            CP_OE <= 3'h0;
            XFER_DONE <= 1'b0;
        end else begin
            RDATA <= rdata_next;
            BP_OUT <= byte_latch_reg;
            BP_OE <= oe_next;
            CP_OUT <= ctrl_latch_reg;
            CP_OE <= ~ctrl_dir_reg;
            XFER_DONE <= done_next;
        end
    end

endmodule

`default_nettype wire

//--- verilog/byte_port_map.vh
// Register offsets, field positions, pin positions, reset values and synchroniser depth for the byte port
`ifndef BYTE_PORT_MAP_VH
`define BYTE_PORT_MAP_VH

// Register offsets on the register port
`define OFS_BYTE_DATA 8'h08
`define OFS_CTRL_DATA 8'h09
`define OFS_BYTE_DIR 8'h88
`define OFS_CTRL_DIR_STAT 8'h89
`define OFS_ANALOG_CFG 8'h9F

// Fields of the control direction and slave status register
`define BIT_IN_FULL 7
`define BIT_OUT_FULL 6
`define BIT_IN_OVF 5
`define BIT_SLAVE_MODE 4
`define BIT_UNUSED 3

// Control pin positions
`define PIN_READ 0
`define PIN_WRITE 1
`define PIN_SELECT 2

// Reset values
`define RST_BYTE_DIR 8'hFF
`define RST_CTRL_DIR 3'h7
`define RST_ANALOG_CFG 3'h0
`define RST_BYTE_LATCH 8'h00

// Synchroniser depth for pin inputs
`define SYNC_STAGES 2

`endif
